// ---- hw/scsw_regs.vh ----
// Constants for the servo status word framer: offsets, field positions, filter codes, reset values, frame byte and irq bits.
`ifndef SCSW_REGS_VH
`define SCSW_REGS_VH
// Register byte offsets on the AXI4-Lite bus.
`define SCSW_OFF_CTRL 12'h000
`define SCSW_OFF_STATUS 12'h004
`define SCSW_OFF_IRQ_STAT 12'h008
`define SCSW_OFF_IRQ_MASK 12'h00C
`define SCSW_OFF_WORD 12'h010
// Status word field positions.
`define SCSW_BIT_HALT 0
`define SCSW_BIT_ABORT 1
`define SCSW_POS_FILT 4
`define SCSW_BIT_LATCH 8
`define SCSW_BIT_POSOK 10
`define SCSW_BIT_PWR 11
`define SCSW_BIT_MRDY 12
// Monitor echo positions follow the command field layout, sized for the placement function's shift input.
`define SCSW_POS_MON1 5'h10
`define SCSW_POS_MON2 5'h13
`define SCSW_POS_MON3 5'h17
// Control register fields.
`define SCSW_CTRL_HALT 0
`define SCSW_CTRL_ABORT 1
`define SCSW_CTRL_FILT 4
// Filter codes.
`define SCSW_FILT_NONE 2'h0
`define SCSW_FILT_RSVD 2'h3
// Reset values.
`define SCSW_CTRL_RST 32'h0000_0000
`define SCSW_MASK_RST 4'h0
// Byte index of the word's first byte within the response frame.
`define SCSW_FRAME_BYTE0 3'h4
// Irq status bits.
`define SCSW_IRQ_HALT 0
`define SCSW_IRQ_ABORT 1
`define SCSW_IRQ_LATCH 2
`define SCSW_IRQ_POSERR 3
`endif

// ---- hw/scsw_top.v ----
// Servo status word builder with AXI4-Lite registers and response byte server.
`timescale 1ns/1ps
`include "scsw_regs.vh"
module scsw_top #(
  parameter IRQ_W = 4
) (
  input wire mclk,
  input wire rst_b,
  // AXI4-Lite slave.
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Motion core status, same clock domain.
  input wire halt_finished,
  input wire abort_finished,
  input wire latch_captured,
  input wire link_established,
  input wire encoder_error,
  input wire motor_ready,
  input wire command_alarm,
  // Asynchronous main power sense pin.
  input wire main_power_pin,
  // Command control field from the master.
  input wire [31:0] command_control,
  // Response frame byte serving.
  input wire frame_tick,
  input wire [2:0] frame_byte_index,
  output reg [7:0] frame_byte,
  output reg [31:0] servo_status_word,
  output reg irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register and state storage.
  reg [31:0] ctrl_reg; // Software control: halt, abort request and filter select.
  reg [IRQ_W-1:0] irq_stat_reg; // Sticky event flags.
  reg [IRQ_W-1:0] irq_mask_reg; // Enables for the flags.
  reg halt_done_flag; // Halt completion state.
  reg abort_done_flag; // Abort completion state.
  reg latch_done_flag; // Latch completion state.
  reg pos_valid_reg; // Position data validity.
  reg [1:0] active_reference_filter; // Filter now applied.
  reg pwr_meta_reg; // First synchroniser stage, read only by the second.
  reg main_power_flag; // Synchronised power state.
  reg latch_req_prev_reg; // Previous latch request bit.
  reg [11:0] waddr_reg; // Captured write address.
  reg aw_have_reg; // Write address held.
  reg [31:0] wdata_reg; // Captured write data.
  reg [3:0] wstrb_reg; // Captured strobes.
  reg w_have_reg; // Write data held.
  wire halt_req; // Halt requested by software or the master.
  wire abort_req; // Abort requested.
  wire latch_request_bit; // Master latch request.
  wire [3:0] monitor_choice_one; // Monitor selection one.
  wire [3:0] monitor_choice_two; // Monitor selection two.
  wire [3:0] monitor_choice_three; // Monitor selection three.
  wire [31:0] word_next; // Assembled status word.
  wire [IRQ_W-1:0] irq_events; // Event pulses this cycle.
  wire do_write; // Write commits this cycle.
  wire [31:0] irq_wclr; // Clear pattern from a write.
  wire halt_rise; // Halt completes now.
  wire abort_rise; // Abort completes now.
  wire latch_rise; // Latch completes now.
  wire pos_fall; // Position data lost now.

  // Requests from either source; the master's pause and cancel bits share the low positions.
  assign halt_req = ctrl_reg[`SCSW_CTRL_HALT] | command_control[`SCSW_CTRL_HALT];
  assign abort_req = ctrl_reg[`SCSW_CTRL_ABORT] | command_control[`SCSW_CTRL_ABORT];
  assign latch_request_bit = command_control[8];
  // Monitor one is three bits wide on the command side; its top bit is forced to zero.
  assign monitor_choice_one = {1'b0, command_control[18:16]};
  assign monitor_choice_two = command_control[22:19];
  assign monitor_choice_three = command_control[26:23];

  ////////////////////////////////////////////////////////////////////////////
  // Function to place a 4-bit field into a word; used for all monitor echoes.
  function [31:0] scsw_place4;
    input [3:0] val;
    input [4:0] pos;
    begin
      scsw_place4 = {28'h000_0000, val} << pos;
    end
  endfunction

  // Assemble the word; reserved bits stay zero. No term depends on alarm.
  assign word_next = ({31'h0000_0000, halt_done_flag} << `SCSW_BIT_HALT)
    | ({31'h0000_0000, abort_done_flag} << `SCSW_BIT_ABORT)
    | ({30'h0000_0000, active_reference_filter} << `SCSW_POS_FILT)
    | ({31'h0000_0000, latch_done_flag} << `SCSW_BIT_LATCH)
    | ({31'h0000_0000, pos_valid_reg} << `SCSW_BIT_POSOK)
    | ({31'h0000_0000, main_power_flag} << `SCSW_BIT_PWR)
    | ({31'h0000_0000, motor_ready} << `SCSW_BIT_MRDY)
    | scsw_place4(monitor_choice_one, `SCSW_POS_MON1)
    | scsw_place4(monitor_choice_two, `SCSW_POS_MON2)
    | (scsw_place4(monitor_choice_three, `SCSW_POS_MON3) & 32'h07FF_FFFF);

  assign halt_rise = halt_req & halt_finished & ~halt_done_flag;
  assign abort_rise = abort_req & abort_finished & ~abort_done_flag;
  // A capture on the request's first cycle is ignored by the flag, so the event ignores it too.
  assign latch_rise = latch_request_bit & latch_req_prev_reg & latch_captured & ~latch_done_flag;
  assign pos_fall = pos_valid_reg & encoder_error;
  assign irq_events = {pos_fall, latch_rise, abort_rise, halt_rise};
  assign do_write = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  assign irq_wclr = (do_write && waddr_reg == `SCSW_OFF_IRQ_STAT) ? wdata_reg : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Power sense passes two flops before use.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_meta_reg <= 1'b0;
      main_power_flag <= 1'b0;
    end else begin
      pwr_meta_reg <= main_power_pin;
      main_power_flag <= pwr_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion flags. The motion core's done inputs cover every move kind alike.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      halt_done_flag <= 1'b0;
      abort_done_flag <= 1'b0;
      latch_done_flag <= 1'b0;
      latch_req_prev_reg <= 1'b0;
      pos_valid_reg <= 1'b0;
      active_reference_filter <= `SCSW_FILT_NONE;
    end else begin
      // Done only while requested and finished; low while the request is pending.
      halt_done_flag <= halt_req & halt_finished;
      abort_done_flag <= abort_req & abort_finished;
      latch_req_prev_reg <= latch_request_bit;
      // A fresh request edge starts a new latch; done holds until the request drops.
      if (!latch_request_bit || (latch_request_bit && !latch_req_prev_reg)) begin
        latch_done_flag <= 1'b0;
      end else if (latch_captured) begin
        latch_done_flag <= 1'b1;
      end
      // Encoder error wins over link establishment because data is then untrustworthy.
      if (encoder_error) begin
        pos_valid_reg <= 1'b0;
      end else if (link_established) begin
        pos_valid_reg <= 1'b1;
      end
      // The reserved filter code is never reported; the previous filter stays.
      if (ctrl_reg[`SCSW_CTRL_FILT+1:`SCSW_CTRL_FILT] != `SCSW_FILT_RSVD) begin
        active_reference_filter <= ctrl_reg[`SCSW_CTRL_FILT+1:`SCSW_CTRL_FILT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word output refreshed every cycle, frame byte on each frame tick, alarm or not.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      servo_status_word <= 32'h0000_0000;
      frame_byte <= 8'h00;
    end else begin
      servo_status_word <= word_next;
      if (frame_tick) begin
        // Bytes four to seven carry the word, least significant first.
        if (frame_byte_index >= `SCSW_FRAME_BYTE0) begin
          frame_byte <= word_next[{frame_byte_index[1:0], 3'b000} +: 8];
        end else begin
          frame_byte <= 8'h00;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags: set wins over write-one-to-clear.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_reg <= {IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_wclr[IRQ_W-1:0]) | irq_events;
      irq <= |(((irq_stat_reg & ~irq_wclr[IRQ_W-1:0]) | irq_events) & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order, response after both.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      waddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      ctrl_reg <= `SCSW_CTRL_RST;
      irq_mask_reg <= `SCSW_MASK_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        waddr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (waddr_reg)
          `SCSW_OFF_CTRL: begin
            if (wstrb_reg[0]) begin
              ctrl_reg[7:0] <= wdata_reg[7:0];
            end
          end
          `SCSW_OFF_IRQ_MASK: begin
            if (wstrb_reg[0]) begin
              irq_mask_reg <= wdata_reg[IRQ_W-1:0];
            end
          end
          `SCSW_OFF_IRQ_STAT: begin
            // Clearing is handled in the interrupt process.
            s_axi_bresp <= 2'b00;
          end
          default: begin
            // Read-only or unmapped offsets answer with a slave error.
            s_axi_bresp <= 2'b10;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path: one read at a time, data one cycle after the address.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `SCSW_OFF_CTRL: s_axi_rdata <= ctrl_reg;
          `SCSW_OFF_STATUS: s_axi_rdata <= {30'h0000_0000, command_alarm, main_power_flag};
          `SCSW_OFF_IRQ_STAT: s_axi_rdata <= {{(32-IRQ_W){1'b0}}, irq_stat_reg};
          `SCSW_OFF_IRQ_MASK: s_axi_rdata <= {{(32-IRQ_W){1'b0}}, irq_mask_reg};
          `SCSW_OFF_WORD: s_axi_rdata <= servo_status_word;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // scsw_top

// ---- bench/scsw_assertions.sv ----
// Checker for the servo status word framer, bound to its top ports.
`timescale 1ns/1ps
module scsw_assertions (
  input wire mclk,
  input wire rst_b,
  input wire [31:0] servo_status_word,
  input wire [31:0] command_control,
  input wire halt_finished,
  input wire abort_finished,
  input wire encoder_error,
  input wire main_power_pin,
  input wire frame_tick,
  input wire [2:0] frame_byte_index,
  input wire [7:0] frame_byte
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Index of the previous cycle; the served byte is taken from the word that is registered with it.
  logic [1:0] tick_idx_q;
  always @(posedge mclk) begin
    tick_idx_q <= frame_byte_index[1:0];
  end
  ////////////////////////////////////////////////////////////////////////
  property p_frame_word;
    frame_tick && frame_byte_index[2] |=> frame_byte == servo_status_word[{tick_idx_q, 3'b000} +: 8];
  endproperty
  a_frame_word: assert property (p_frame_word) else $error("frame byte differs from word");
  property p_frame_low; frame_tick && !frame_byte_index[2] |=> frame_byte == 8'h00; endproperty
  a_frame_low: assert property (p_frame_low) else $error("header byte not zero");
  // The done flag and the word register each add one cycle.
  property p_halt; !halt_finished |-> ##2 !servo_status_word[0]; endproperty
  a_halt: assert property (p_halt) else $error("halt done without finish");
  property p_abort; !abort_finished |-> ##2 !servo_status_word[1]; endproperty
  a_abort: assert property (p_abort) else $error("abort done without finish");
  property p_filter; servo_status_word[5:4] != 2'h3; endproperty
  a_filter: assert property (p_filter) else $error("reserved filter code shown");
  property p_latch; !command_control[8] [*2] |=> !servo_status_word[8]; endproperty
  a_latch: assert property (p_latch) else $error("latch done held without request");
  property p_enc; encoder_error [*2] |=> !servo_status_word[10]; endproperty
  a_enc: assert property (p_enc) else $error("position valid during encoder error");
  property p_pwr; main_power_pin [*4] |=> servo_status_word[11]; endproperty
  a_pwr: assert property (p_pwr) else $error("power flag not set");
  property p_mon; 1 |=> servo_status_word[26:16] == $past(command_control[26:16]); endproperty
  a_mon: assert property (p_mon) else $error("monitor echo wrong");
  property p_rsvd; (servo_status_word & 32'hF800_E2CC) == 32'h0000_0000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
endmodule // scsw_assertions

// ---- bench/scsw_master.sv ----
// Network master model: drives the control field and collects response bytes.
`timescale 1ns/1ps
module scsw_master (
  input wire logic mclk,
  output logic [31:0] command_control,
  output logic frame_tick,
  output logic [2:0] frame_byte_index,
  input wire logic [7:0] frame_byte
);
  initial begin
    command_control = 32'h0000_0000;
    frame_tick = 0;
    frame_byte_index = 3'h0;
  end
  // The control field is a level, held until the next command cycle.
  task set_cc(input [31:0] v);
    @(posedge mclk);
    command_control <= v;
  endtask
  // Walks the whole frame so header bytes are served too; keeps bytes four to seven, LSB first.
  task get_word(output [31:0] w);
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      frame_tick <= 1;
      frame_byte_index <= i[2:0];
      @(posedge mclk);
      frame_tick <= 0;
      @(negedge mclk);
      if (i >= 4) begin
        w[8*(i-4) +: 8] = frame_byte;
      end
    end
  endtask
endmodule // scsw_master

// ---- bench/scsw_top_test.sv ----
// Self-checking bench for the servo status word framer.
`timescale 1ns/1ps
`define CK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module scsw_top_test;
  logic mclk = 0, rst_b = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic halt_finished = 0, abort_finished = 0, latch_captured = 0, link_established = 0;
  logic encoder_error = 0, motor_ready = 0, command_alarm = 0, main_power_pin = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, frame_tick;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, servo_status_word, command_control;
  wire [7:0] frame_byte;
  wire [2:0] frame_byte_index;
  int mismatches = 0, checked = 0, cycles = 0;
  logic [31:0] d, f;
  always #10 mclk = ~mclk;
  scsw_top u_dut (.mclk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .halt_finished, .abort_finished,
    .latch_captured, .link_established, .encoder_error, .motor_ready, .command_alarm, .main_power_pin,
    .command_control, .frame_tick, .frame_byte_index, .frame_byte, .servo_status_word, .irq);
  scsw_master u_m (.mclk, .command_control, .frame_tick, .frame_byte_index, .frame_byte);
  ////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // A hang in any handshake loop ends here instead of running forever.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      close_out;
    end
  end
  task nc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Readies are looked at mid-cycle, so each handshake edge is known before it arrives.
  task wr(input [11:0] a, input [31:0] v, input [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge mclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'b111};
    tb = 0;
    while (!tb) begin
      @(negedge mclk);
      {ta, tw, tb, r} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    `CK("bresp", er, r)
  endtask
  task rd(input [11:0] a, input [1:0] er, output [31:0] v);
    logic ta, tr;
    logic [1:0] r;
    @(posedge mclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    tr = 0;
    while (!tr) begin
      @(negedge mclk);
      {ta, tr, r, v} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata};
      @(posedge mclk);
      if (ta) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    `CK("rresp", er, r)
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1;
    nc(2);
    `CK("word", 32'h0000_0000, servo_status_word)
    for (int i = 0; i < 4; i++) begin
      wr(12'h000, i << 4, 2'h0);
      nc(3);
      `CK("filter", (i == 3) ? 2'h2 : i[1:0], servo_status_word[5:4])
    end
    @(posedge mclk) command_alarm <= 1;
    wr(12'h000, 32'h0000_0021, 2'h0);
    nc(3);
    `CK("halt", 1'b0, servo_status_word[0])
    @(posedge mclk) halt_finished <= 1;
    nc(3);
    `CK("halt", 1'b1, servo_status_word[0])
    `CK("irq", 1'b0, irq)
    wr(12'h00C, 32'h0000_0001, 2'h0);
    nc(3);
    `CK("irq", 1'b1, irq)
    @(posedge mclk) halt_finished <= 0;
    wr(12'h008, 32'h0000_0001, 2'h0);
    nc(3);
    `CK("irq", 1'b0, irq)
    rd(12'h004, 2'h0, d);
    `CK("alarm", 1'b1, d[1])
    u_m.set_cc(32'h0000_0002);
    nc(3);
    `CK("abort", 1'b0, servo_status_word[1])
    @(posedge mclk) abort_finished <= 1;
    nc(3);
    `CK("abort", 1'b1, servo_status_word[1])
    u_m.set_cc(32'h0000_0100);
    nc(3);
    @(posedge mclk) latch_captured <= 1;
    @(posedge mclk) latch_captured <= 0;
    nc(6);
    `CK("latch", 1'b1, servo_status_word[8])
    u_m.set_cc(32'h0000_0000);
    nc(3);
    `CK("latch", 1'b0, servo_status_word[8])
    @(posedge mclk) link_established <= 1;
    @(posedge mclk) link_established <= 0;
    nc(3);
    `CK("posok", 1'b1, servo_status_word[10])
    @(posedge mclk) encoder_error <= 1;
    nc(3);
    `CK("posok", 1'b0, servo_status_word[10])
    @(posedge mclk) {main_power_pin, motor_ready} <= 2'b11;
    nc(5);
    `CK("power", 1'b1, servo_status_word[11])
    `CK("mready", 1'b1, servo_status_word[12])
    u_m.set_cc(32'h07FF_0000);
    nc(3);
    `CK("monitor", 11'h7FF, servo_status_word[26:16])
    `CK("reserved", 32'h0000_0000, servo_status_word & 32'hF800_E2CC)
    u_m.get_word(f);
    `CK("frame", servo_status_word, f)
    rd(12'h010, 2'h0, d);
    `CK("wordreg", servo_status_word, d)
    wr(12'h010, 32'h0000_0000, 2'h2);
    rd(12'h020, 2'h2, d);
    close_out;
  end
endmodule // scsw_top_test
bind scsw_top scsw_assertions u_chk (.mclk, .rst_b, .servo_status_word, .command_control, .halt_finished,
  .abort_finished, .encoder_error, .main_power_pin, .frame_tick, .frame_byte_index, .frame_byte);
